// [verilog/cfm_clock_fault_monitor.sv]
// cfm_clock_fault_monitor: frequency fault and lock loss monitors with AHB-Lite registers
// assumes frequency words synchronous to hclk, signed, 0.1 ppm per lsb
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - offsets measured against selectable reference, crystal default
// R2 - fault combines precise and fast monitors
// R3 - live fault bit plus sticky flag
// R4 - precise monitor samples over long period
// R5 - precise window 2 to 512 ppm, 2 ppm steps
// R6 - separate precise set and clear thresholds
// R7 - fast monitor flags large frequency moves
// R8 - fast monitor own set and clear thresholds
// R9 - per input enable for each monitor
// R10 - fault sticky cleared by writing zero
// R11 - lock loss live bit and pin
// R12 - compare input and feedback frequency
// R13 - lock thresholds from eleven ppm steps
// R14 - programmable 35-bit lock clear delay
// R15 - timer enable bypasses or applies delay
// R16 - lock sticky cleared by writing zero
// R17 - status changes interrupt, each maskable
// R18 - interrupt releases when flag cleared
// R19 - host reads unmasked flags then clears
// R20 - interrupt low while unmasked flag set
// R21 - clear accepted only while alarm low
// R22 - host finds source as flag and not mask
// R23 - set wins over coincident clear
module cfm_clock_fault_monitor #(
    parameter int PRECISE_CYCLES = cfm_pkg::PRECISE_PERIOD_CYCLES,
    parameter int FAST_CYCLES = cfm_pkg::FAST_PERIOD_CYCLES,
    parameter int TICK_CYCLES = cfm_pkg::DELAY_TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic signed [cfm_pkg::FW-1:0] crystal_reference_freq,
    input wire logic signed [cfm_pkg::FW-1:0] input_clock_zero_freq,
    input wire logic signed [cfm_pkg::FW-1:0] input_clock_one_freq,
    input wire logic signed [cfm_pkg::FW-1:0] phase_detector_input_freq,
    input wire logic signed [cfm_pkg::FW-1:0] phase_detector_feedback_freq,
    output logic interrupt_pin_n,
    output logic lock_loss_pin
);
    import cfm_pkg::*;

    function automatic logic [FW-1:0] abs_diff(input logic signed [FW-1:0] a,
                                               input logic signed [FW-1:0] b);
        logic signed [FW:0] d;
        d = {a[FW-1], a} - {b[FW-1], b};
        abs_diff = d[FW] ? FW'(-d) : d[FW-1:0];
    endfunction

    // lock threshold codes in 0.1 ppm units
    function automatic logic [FW-1:0] lock_threshold(input logic [3:0] code);
        unique case (code)
            4'h0: lock_threshold = 24'h000002;
            4'h1: lock_threshold = 24'h000006;
            4'h2: lock_threshold = 24'h000014;
            4'h3: lock_threshold = 24'h00003c;
            4'h4: lock_threshold = 24'h0000c8;
            4'h5: lock_threshold = 24'h000258;
            4'h6: lock_threshold = 24'h0007d0;
            4'h7: lock_threshold = 24'h001770;
            4'h8: lock_threshold = 24'h004e20;
            4'h9: lock_threshold = 24'h00ea60;
            default: lock_threshold = 24'h030d40;
        endcase
    endfunction

    // bus registers
    cfm_bus_state_type bus_state;
    logic [7:0] bus_index;
    logic [31:0] read_word;
    logic [1:0] precise_monitor_enable;
    logic [1:0] fast_monitor_enable;
    logic [2:0] freq_reference_select;
    logic [15:0] precise_set_threshold;
    logic [15:0] precise_clear_threshold;
    logic [15:0] fast_set_threshold;
    logic [15:0] fast_clear_threshold;
    logic [3:0] lock_loss_set_threshold;
    logic [3:0] lock_loss_clear_threshold;
    logic lock_clear_timer_enable;
    logic [34:0] lock_clear_delay_value;
    logic [1:0] freq_fault_mask;
    logic lock_loss_mask;
    // monitor state
    logic [1:0] precise_fault;
    logic [1:0] fast_fault;
    logic [1:0] freq_fault_live;
    logic [1:0] freq_fault_sticky;
    logic lock_loss_live;
    logic lock_loss_sticky;
    logic [31:0] precise_count;
    logic [15:0] fast_count;
    logic [15:0] tick_count;
    logic [34:0] delay_count;
    logic signed [FW-1:0] reference_freq;
    logic [FW-1:0] offset [2];
    logic [FW-1:0] lock_offset;
    logic precise_strobe;
    logic fast_strobe;
    logic delay_tick;
    logic write_now;
    logic [1:0] freq_clear;
    logic lock_clear;

    assign hresp = 1'b0;
    assign hreadyout = (bus_state != CFM_BUS_READ_WAIT);
    assign write_now = (bus_state == CFM_BUS_WRITE);

    // address phase capture; reads take one wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= CFM_BUS_IDLE;
            bus_index <= 8'h00;
        end else if (bus_state == CFM_BUS_READ_WAIT) begin
            bus_state <= CFM_BUS_READ_DONE;
        end else if (hready && hsel && htrans[1]) begin
            bus_index <= haddr[9:2];
            bus_state <= hwrite ? CFM_BUS_WRITE : CFM_BUS_READ_WAIT;
        end else if (hready) begin
            bus_state <= CFM_BUS_IDLE;
        end
    end

    always_comb begin
        read_word = 32'h00000000;
        unique case (bus_index)
            IDX_FREQ_FAULT_LIVE: read_word[POS_FREQ_FAULT +: 2] = freq_fault_live;
            IDX_LOCK_LOSS_LIVE: read_word[POS_LOCK_LOSS] = lock_loss_live;
            IDX_FREQ_FAULT_STICKY: read_word[POS_FREQ_FAULT +: 2] = freq_fault_sticky;
            IDX_LOCK_LOSS_STICKY: read_word[POS_LOCK_LOSS] = lock_loss_sticky;
            IDX_FREQ_FAULT_MASK: read_word[POS_FREQ_FAULT +: 2] = freq_fault_mask;
            IDX_LOCK_LOSS_MASK: read_word[POS_LOCK_LOSS] = lock_loss_mask;
            IDX_MONITOR_ENABLE: begin
                read_word[POS_PRECISE_EN +: 2] = precise_monitor_enable;
                read_word[POS_FAST_EN +: 2] = fast_monitor_enable;
            end
            IDX_FREQ_REFERENCE_SELECT: read_word[2:0] = freq_reference_select;
            IDX_PRECISE_SET_THRESHOLD: read_word[15:0] = precise_set_threshold;
            IDX_PRECISE_CLEAR_THRESHOLD: read_word[15:0] = precise_clear_threshold;
            IDX_FAST_SET_THRESHOLD: read_word[15:0] = fast_set_threshold;
            IDX_FAST_CLEAR_THRESHOLD: read_word[15:0] = fast_clear_threshold;
            IDX_LOCK_LOSS_SET_THRESHOLD: read_word[POS_LOCK_THR +: 4] = lock_loss_set_threshold;
            IDX_LOCK_LOSS_CLEAR_THRESHOLD:
                read_word[POS_LOCK_THR +: 4] = lock_loss_clear_threshold;
            IDX_LOCK_CLEAR_TIMER_ENABLE: read_word[POS_TIMER_EN] = lock_clear_timer_enable;
            IDX_LOCK_CLEAR_DELAY_LOW: read_word = lock_clear_delay_value[31:0];
            IDX_LOCK_CLEAR_DELAY_HIGH: read_word[2:0] = lock_clear_delay_value[34:32];
            default: read_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (bus_state == CFM_BUS_READ_WAIT) begin
            hrdata <= read_word;
        end
    end

    // control register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            precise_monitor_enable <= RST_ENABLE;
            fast_monitor_enable <= RST_ENABLE;
            freq_reference_select <= RST_REF_SELECT;
            precise_set_threshold <= RST_PRECISE_SET;
            precise_clear_threshold <= RST_PRECISE_CLEAR;
            fast_set_threshold <= RST_FAST_SET;
            fast_clear_threshold <= RST_FAST_CLEAR;
            lock_loss_set_threshold <= RST_LOCK_SET_THR;
            lock_loss_clear_threshold <= RST_LOCK_CLEAR_THR;
            lock_clear_timer_enable <= 1'b0;
            lock_clear_delay_value <= 35'h000000000;
            freq_fault_mask <= RST_FREQ_MASK;
            lock_loss_mask <= RST_LOCK_MASK;
        end else if (write_now) begin
            unique case (bus_index)
                IDX_MONITOR_ENABLE: begin
                    precise_monitor_enable <= hwdata[POS_PRECISE_EN +: 2]; // R9
                    fast_monitor_enable <= hwdata[POS_FAST_EN +: 2]; // R9
                end
                IDX_FREQ_REFERENCE_SELECT: freq_reference_select <= hwdata[2:0];
                IDX_PRECISE_SET_THRESHOLD: precise_set_threshold <= hwdata[15:0];
                IDX_PRECISE_CLEAR_THRESHOLD: precise_clear_threshold <= hwdata[15:0];
                IDX_FAST_SET_THRESHOLD: fast_set_threshold <= hwdata[15:0];
                IDX_FAST_CLEAR_THRESHOLD: fast_clear_threshold <= hwdata[15:0];
                IDX_LOCK_LOSS_SET_THRESHOLD:
                    lock_loss_set_threshold <= hwdata[POS_LOCK_THR +: 4];
                IDX_LOCK_LOSS_CLEAR_THRESHOLD:
                    lock_loss_clear_threshold <= hwdata[POS_LOCK_THR +: 4];
                IDX_LOCK_CLEAR_TIMER_ENABLE: lock_clear_timer_enable <= hwdata[POS_TIMER_EN];
                IDX_LOCK_CLEAR_DELAY_LOW: lock_clear_delay_value[31:0] <= hwdata;
                IDX_LOCK_CLEAR_DELAY_HIGH: lock_clear_delay_value[34:32] <= hwdata[2:0];
                IDX_FREQ_FAULT_MASK: freq_fault_mask <= hwdata[POS_FREQ_FAULT +: 2]; // R17
                IDX_LOCK_LOSS_MASK: lock_loss_mask <= hwdata[POS_LOCK_LOSS]; // R17
                default: ;
            endcase
        end
    end

    // reference choice and offsets
    always_comb begin
        unique case (freq_reference_select)
            REF_INPUT_ZERO: reference_freq = input_clock_zero_freq; // R1
            REF_INPUT_ONE: reference_freq = input_clock_one_freq; // R1
            default: reference_freq = crystal_reference_freq; // R1
        endcase
    end

    assign offset[0] = abs_diff(input_clock_zero_freq, reference_freq);
    assign offset[1] = abs_diff(input_clock_one_freq, reference_freq);
    assign lock_offset = abs_diff(phase_detector_input_freq, phase_detector_feedback_freq); // R12

    // measurement period dividers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            precise_count <= 32'h00000000;
        end else if (precise_strobe) begin
            precise_count <= 32'h00000000;
        end else begin
            precise_count <= precise_count + 32'h00000001;
        end
    end
    assign precise_strobe = (precise_count == 32'(PRECISE_CYCLES - 1)); // R4

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_count <= 16'h0000;
        end else if (fast_strobe) begin
            fast_count <= 16'h0000;
        end else begin
            fast_count <= fast_count + 16'h0001;
        end
    end
    assign fast_strobe = (fast_count == 16'(FAST_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_count <= 16'h0000;
        end else if (delay_tick) begin
            tick_count <= 16'h0000;
        end else begin
            tick_count <= tick_count + 16'h0001;
        end
    end
    assign delay_tick = (tick_count == 16'(TICK_CYCLES - 1));

    // precise and fast monitors with hysteresis
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            precise_fault <= 2'b00;
            fast_fault <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!precise_monitor_enable[i]) begin
                    precise_fault[i] <= 1'b0; // R9
                end else if (precise_strobe) begin
                    if (offset[i] > FW'({16'h0000, precise_set_threshold[8*i +: 8]} + 24'h1)
                            * PRECISE_STEP) begin
                        precise_fault[i] <= 1'b1; // R5 R6
                    end else if (offset[i] <= FW'({16'h0000,
                            precise_clear_threshold[8*i +: 8]} + 24'h1) * PRECISE_STEP) begin
                        precise_fault[i] <= 1'b0; // R6
                    end
                end
                if (!fast_monitor_enable[i]) begin
                    fast_fault[i] <= 1'b0; // R9
                end else if (fast_strobe) begin
                    if (offset[i] > FW'({16'h0000, fast_set_threshold[8*i +: 8]}) * FAST_STEP) begin
                        fast_fault[i] <= 1'b1; // R7 R8
                    end else if (offset[i] <= FW'({16'h0000, fast_clear_threshold[8*i +: 8]})
                            * FAST_STEP) begin
                        fast_fault[i] <= 1'b0; // R8
                    end
                end
            end
        end
    end
    assign freq_fault_live = precise_fault | fast_fault; // R2 R3

    // lock loss with optional clear delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_loss_live <= 1'b1;
            delay_count <= 35'h000000000;
        end else if (lock_offset > lock_threshold(lock_loss_set_threshold)) begin
            lock_loss_live <= 1'b1; // R11 R13
            delay_count <= 35'h000000000;
        end else if (lock_loss_live &&
                lock_offset <= lock_threshold(lock_loss_clear_threshold)) begin
            if (!lock_clear_timer_enable || delay_count >= lock_clear_delay_value) begin
                lock_loss_live <= 1'b0; // R13 R15
                delay_count <= 35'h000000000;
            end else if (delay_tick) begin
                delay_count <= delay_count + 35'h000000001; // R14
            end
        end else if (lock_loss_live) begin
            delay_count <= 35'h000000000;
        end
    end
    assign lock_loss_pin = lock_loss_live; // R11

    // sticky flags, set wins
    assign freq_clear = (write_now && bus_index == IDX_FREQ_FAULT_STICKY) ?
        ~hwdata[POS_FREQ_FAULT +: 2] & ~freq_fault_live : 2'b00; // R10 R21
    assign lock_clear = write_now && bus_index == IDX_LOCK_LOSS_STICKY &&
        !hwdata[POS_LOCK_LOSS] && !lock_loss_live; // R16 R21

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_fault_sticky <= 2'b00;
            lock_loss_sticky <= 1'b0;
        end else begin
            freq_fault_sticky <= freq_fault_live | (freq_fault_sticky & ~freq_clear); // R3 R23
            lock_loss_sticky <= lock_loss_live | (lock_loss_sticky & ~lock_clear); // R16 R23
        end
    end

    // active-low interrupt
    assign interrupt_pin_n = ~(|(freq_fault_sticky & ~freq_fault_mask) |
        (lock_loss_sticky & ~lock_loss_mask)); // R17 R18 R20
endmodule
`default_nettype wire

// [verilog/cfm_pkg.sv]
// cfm_pkg: register map, fields, resets and timing of the fault monitor
// assumes frequency words are signed offsets from nominal in units of 0.1 ppm
package cfm_pkg;
    localparam int FW = 24;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FREQ_FAULT_LIVE = 8'h0d;
    localparam logic [7:0] IDX_LOCK_LOSS_LIVE = 8'h0e;
    localparam logic [7:0] IDX_FREQ_FAULT_STICKY = 8'h12;
    localparam logic [7:0] IDX_LOCK_LOSS_STICKY = 8'h13;
    localparam logic [7:0] IDX_FREQ_FAULT_MASK = 8'h19;
    localparam logic [7:0] IDX_LOCK_LOSS_MASK = 8'h1a;
    localparam logic [7:0] IDX_MONITOR_ENABLE = 8'h3f;
    localparam logic [7:0] IDX_FREQ_REFERENCE_SELECT = 8'h40;
    localparam logic [7:0] IDX_PRECISE_SET_THRESHOLD = 8'h46;
    localparam logic [7:0] IDX_PRECISE_CLEAR_THRESHOLD = 8'h4a;
    localparam logic [7:0] IDX_FAST_SET_THRESHOLD = 8'h51;
    localparam logic [7:0] IDX_FAST_CLEAR_THRESHOLD = 8'h55;
    localparam logic [7:0] IDX_LOCK_LOSS_SET_THRESHOLD = 8'h9e;
    localparam logic [7:0] IDX_LOCK_LOSS_CLEAR_THRESHOLD = 8'ha0;
    localparam logic [7:0] IDX_LOCK_CLEAR_TIMER_ENABLE = 8'ha2;
    localparam logic [7:0] IDX_LOCK_CLEAR_DELAY_LOW = 8'ha8;
    localparam logic [7:0] IDX_LOCK_CLEAR_DELAY_HIGH = 8'ha9;
    // field positions
    localparam int POS_FREQ_FAULT = 4;
    localparam int POS_PRECISE_EN = 0;
    localparam int POS_FAST_EN = 4;
    localparam int POS_LOCK_LOSS = 1;
    localparam int POS_LOCK_THR = 4;
    localparam int POS_TIMER_EN = 1;
    // reset values
    localparam logic [2:0] RST_REF_SELECT = 3'h0;
    localparam logic [1:0] RST_ENABLE = 2'h3;
    localparam logic [15:0] RST_PRECISE_SET = 16'h0202;
    localparam logic [15:0] RST_PRECISE_CLEAR = 16'h0101;
    localparam logic [15:0] RST_FAST_SET = 16'h2828;
    localparam logic [15:0] RST_FAST_CLEAR = 16'h2424;
    localparam logic [3:0] RST_LOCK_SET_THR = 4'h0;
    localparam logic [3:0] RST_LOCK_CLEAR_THR = 4'h2;
    localparam logic [1:0] RST_FREQ_MASK = 2'h3;
    localparam logic RST_LOCK_MASK = 1'b1;
    // threshold scaling, in 0.1 ppm units
    localparam logic [FW-1:0] PRECISE_STEP = 24'h000014;
    localparam logic [FW-1:0] FAST_STEP = 24'h0003e8;
    // reference choices
    localparam logic [2:0] REF_CRYSTAL = 3'h0;
    localparam logic [2:0] REF_INPUT_ZERO = 3'h1;
    localparam logic [2:0] REF_INPUT_ONE = 3'h2;
    // timing
    localparam int CLOCK_MHZ = 100;
    localparam int PRECISE_PERIOD_US = 10000;
    localparam int FAST_PERIOD_NS = 1000;
    localparam int DELAY_TICK_NS = 20;
    localparam int PRECISE_PERIOD_CYCLES = PRECISE_PERIOD_US * CLOCK_MHZ;
    localparam int FAST_PERIOD_CYCLES = FAST_PERIOD_NS * CLOCK_MHZ / 1000;
    localparam int DELAY_TICK_CYCLES = DELAY_TICK_NS * CLOCK_MHZ / 1000;
    typedef enum logic [1:0] {
        CFM_BUS_IDLE = 2'b00,
        CFM_BUS_WRITE = 2'b01,
        CFM_BUS_READ_WAIT = 2'b10,
        CFM_BUS_READ_DONE = 2'b11
    } cfm_bus_state_type;
endpackage

// [test/cfm_clock_fault_monitor_chk.sv]
// cfm_monitor_chk: port checks of the fault monitor
// assumes the single slave drives hready through hreadyout
`timescale 1ns/1ps
`default_nettype none
module cfm_monitor_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic signed [cfm_pkg::FW-1:0] phase_detector_input_freq,
    input wire logic signed [cfm_pkg::FW-1:0] phase_detector_feedback_freq,
    input wire logic interrupt_pin_n,
    input wire logic lock_loss_pin
);
    import cfm_pkg::*;
    logic rd_taken, wr_taken, rd_wait, wr_dphase, lock_big;
    logic signed [FW:0] lock_diff;
    assign rd_taken = hready && hsel && htrans[1] && !hwrite;
    assign wr_taken = hready && hsel && htrans[1] && hwrite;
    assign lock_diff = phase_detector_input_freq - phase_detector_feedback_freq;
    assign lock_big = (lock_diff > 25'sd200000) || (lock_diff < -25'sd200000);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b0;
            wr_dphase <= 1'b0;
        end else begin
            rd_wait <= rd_taken;
            wr_dphase <= wr_taken;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_resp_okay: assert property (!hresp) else $error("resp not okay");
    chk_read_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    chk_write_nowait: assert property (wr_taken |=> hreadyout) else $error("write stalled");
    chk_ready_cause: assert property (!hreadyout |-> rd_wait) else $error("stray wait state");
    chk_data_hold: assert property ($changed(hrdata) |-> $past(rd_wait) || $past(rd_taken))
        else $error("hrdata moved");
    chk_lock_set: assert property (lock_big |-> ##[1:2] lock_loss_pin)
        else $error("lock loss missed");
    chk_lock_fall: assert property ($fell(lock_loss_pin) |-> !$past(lock_big))
        else $error("lock cleared early");
    chk_irq_release: assert property ($rose(interrupt_pin_n) |-> $past(wr_dphase))
        else $error("bad irq release");
    cover property (rd_taken ##2 hreadyout);
    cover property ($fell(interrupt_pin_n));
    cover property ($fell(lock_loss_pin));
endmodule
bind cfm_clock_fault_monitor cfm_monitor_chk cfm_monitor_chk_inst (.*);
`default_nettype wire

// [test/cfm_clock_sources.sv]
// cfm_clock_sources: reference, inputs and loop feedback as offsets
// assumes the loop tracks input zero; offsets in 0.1 ppm units
`timescale 1ns/1ps
`default_nettype none
module cfm_clock_sources (
    input wire logic signed [cfm_pkg::FW-1:0] xtal_offset,
    input wire logic signed [cfm_pkg::FW-1:0] in0_offset,
    input wire logic signed [cfm_pkg::FW-1:0] in1_offset,
    input wire logic signed [cfm_pkg::FW-1:0] loop_error,
    output logic signed [cfm_pkg::FW-1:0] crystal_reference_freq,
    output logic signed [cfm_pkg::FW-1:0] input_clock_zero_freq,
    output logic signed [cfm_pkg::FW-1:0] input_clock_one_freq,
    output logic signed [cfm_pkg::FW-1:0] phase_detector_input_freq,
    output logic signed [cfm_pkg::FW-1:0] phase_detector_feedback_freq
);
    import cfm_pkg::*;
    assign crystal_reference_freq = xtal_offset;
    assign input_clock_zero_freq = in0_offset;
    assign input_clock_one_freq = in1_offset;
    assign phase_detector_input_freq = in0_offset;
    assign phase_detector_feedback_freq = in0_offset - loop_error;
endmodule
`default_nettype wire

// [test/tb.sv]
// tb: self-checking bench
// assumes hreadyout is looped back as hready and hsel stays high
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cfm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, irq_n, lol_pin;
    logic signed [FW-1:0] xtal = '0, in0 = '0, in1 = '0, lock_err = '0;
    logic signed [FW-1:0] f_x, f_0, f_1, f_pi, f_pf;
    int fail_count = 0;
    int tests_run = 0;
    always #5 hclk = ~hclk;
    cfm_clock_sources cfm_clock_sources_inst (.xtal_offset(xtal), .in0_offset(in0),
        .in1_offset(in1), .loop_error(lock_err), .crystal_reference_freq(f_x),
        .input_clock_zero_freq(f_0), .input_clock_one_freq(f_1),
        .phase_detector_input_freq(f_pi), .phase_detector_feedback_freq(f_pf));
    cfm_clock_fault_monitor #(.PRECISE_CYCLES(16), .FAST_CYCLES(4), .TICK_CYCLES(2))
        cfm_clock_fault_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .crystal_reference_freq(f_x), .input_clock_zero_freq(f_0),
        .input_clock_one_freq(f_1), .phase_detector_input_freq(f_pi),
        .phase_detector_feedback_freq(f_pf), .interrupt_pin_n(irq_n),
        .lock_loss_pin(lol_pin));
    task automatic test_done;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy;
        int n = 0;
        logic r;
        do begin
            #1 r = hreadyout;
            @(posedge hclk);
            n++;
        end while (r !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("wrong value at %0t: bus timeout", $time);
            test_done;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic t_defaults;
        logic [7:0] idx [13] = '{8'h0d, 8'h12, 8'h13, 8'h19, 8'h1a, 8'h3f, 8'h40, 8'h46,
            8'h4a, 8'h51, 8'h55, 8'h9e, 8'ha0};
        logic [31:0] val [13] = '{32'h0, 32'h0, 32'h2, 32'h30, 32'h2, 32'h33, 32'h0,
            32'h202, 32'h101, 32'h2828, 32'h2424, 32'h0, 32'h20};
        for (int i = 0; i < 13; i++) begin
            rdchk(idx[i], val[i]);
        end
        wr(8'h20, 32'hffffffff);
        rdchk(8'h20, 32'h0);
    endtask
    task automatic t_lock_codes;
        int thr [11] = '{2, 6, 20, 60, 200, 600, 2000, 6000, 20000, 60000, 200000};
        wr(IDX_LOCK_CLEAR_TIMER_ENABLE, 32'h0);
        for (int k = 0; k < 11; k++) begin
            wr(IDX_LOCK_LOSS_SET_THRESHOLD, 32'(k) << 4);
            wr(IDX_LOCK_LOSS_CLEAR_THRESHOLD, 32'(k) << 4);
            lock_err <= FW'(thr[k] + 1);
            settle(3);
            check(lol_pin, 1'b1);
            rdchk(IDX_LOCK_LOSS_LIVE, 32'h2);
            lock_err <= FW'(thr[k]);
            settle(3);
            check(lol_pin, 1'b0);
        end
        wr(IDX_LOCK_LOSS_SET_THRESHOLD, 32'h0);
        wr(IDX_LOCK_LOSS_CLEAR_THRESHOLD, 32'h20);
    endtask
    task automatic t_lock_timer;
        int n;
        wr(IDX_LOCK_CLEAR_DELAY_HIGH, 32'h7);
        rdchk(IDX_LOCK_CLEAR_DELAY_HIGH, 32'h7);
        wr(IDX_LOCK_CLEAR_DELAY_HIGH, 32'h0);
        wr(IDX_LOCK_CLEAR_DELAY_LOW, 32'h5);
        wr(IDX_LOCK_CLEAR_TIMER_ENABLE, 32'h2);
        lock_err <= FW'(1000);
        settle(3);
        lock_err <= '0;
        n = 0;
        while (lol_pin !== 1'b0 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        check(32'(n >= 9 && n <= 14), 32'h1);
        if (n >= 100) test_done;
        wr(IDX_LOCK_CLEAR_TIMER_ENABLE, 32'h0);
    endtask
    task automatic t_lock_sticky;
        wr(IDX_LOCK_LOSS_MASK, 32'h0);
        settle(1);
        check(irq_n, 1'b0);
        rdchk(IDX_LOCK_LOSS_STICKY, 32'h2);
        wr(IDX_LOCK_LOSS_STICKY, 32'h0);
        settle(1);
        check(irq_n, 1'b1);
        rdchk(IDX_LOCK_LOSS_STICKY, 32'h0);
        lock_err <= FW'(1000);
        settle(3);
        wr(IDX_LOCK_LOSS_STICKY, 32'h0);
        rdchk(IDX_LOCK_LOSS_STICKY, 32'h2);
        check(irq_n, 1'b0);
        lock_err <= '0;
        settle(3);
        wr(IDX_LOCK_LOSS_STICKY, 32'h0);
        settle(1);
        check(irq_n, 1'b1);
    endtask
    task automatic t_freq;
        wr(IDX_FREQ_FAULT_MASK, 32'h0);
        in0 <= FW'(100);
        settle(40);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h10);
        check(irq_n, 1'b0);
        in0 <= FW'(50);
        settle(40);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h10);
        in0 <= FW'(30);
        settle(40);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h0);
        rdchk(IDX_FREQ_FAULT_STICKY, 32'h10);
        wr(IDX_FREQ_FAULT_STICKY, 32'h0);
        rdchk(IDX_FREQ_FAULT_STICKY, 32'h0);
        check(irq_n, 1'b1);
        in0 <= FW'(100);
        in1 <= FW'(100);
        wr(IDX_FREQ_REFERENCE_SELECT, 32'(REF_INPUT_ONE));
        settle(40);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h0);
        wr(IDX_FREQ_REFERENCE_SELECT, 32'(REF_INPUT_ZERO));
        settle(40);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h0);
        wr(IDX_FREQ_REFERENCE_SELECT, 32'(REF_CRYSTAL));
        settle(40);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h30);
        in0 <= '0;
        in1 <= '0;
        settle(40);
    endtask
    task automatic t_fast;
        wr(IDX_MONITOR_ENABLE, 32'h31);
        in1 <= FW'(50000);
        settle(12);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h20);
        wr(IDX_FAST_SET_THRESHOLD, 32'h3c28);
        in1 <= '0;
        settle(12);
        in1 <= FW'(50000);
        settle(12);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h0);
        in1 <= '0;
        wr(IDX_MONITOR_ENABLE, 32'h11);
        wr(IDX_FAST_SET_THRESHOLD, 32'h2828);
        in1 <= FW'(50000);
        settle(12);
        rdchk(IDX_FREQ_FAULT_LIVE, 32'h0);
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        check(lol_pin, 1'b1);
        check(irq_n, 1'b1);
        hresetn <= 1'b1;
        settle(40);
        t_defaults;
        t_lock_codes;
        t_lock_timer;
        t_lock_sticky;
        t_freq;
        t_fast;
        test_done;
    end
endmodule
`default_nettype wire
